// ===== rtl/bsfx_consts.svh
`ifndef BSFX_CONSTS_SVH
`define BSFX_CONSTS_SVH
// Flag positions inside the status flag register.
`define BSFX_FLG_C 3'd0
`define BSFX_FLG_Z 3'd1
`define BSFX_FLG_N 3'd2
`define BSFX_FLG_V 3'd3
`define BSFX_FLG_S 3'd4
`define BSFX_FLG_H 3'd5
`define BSFX_FLG_T 3'd6
`define BSFX_FLG_I 3'd7
`define BSFX_FLAGS_RST 8'h00
`define BSFX_BYTE_ZERO 8'h00
`define BSFX_MSB 3'd7
`define BSFX_LSB 3'd0
`define BSFX_CYC_TWO 2'd2
`define BSFX_CYC_ONE 2'd1
`endif

// ===== rtl/bsfx_pkg.sv
package bsfx_pkg;
  typedef enum logic [4:0] {
    BSFX_OP_NONE        = 5'h00,
    BSFX_OP_PUSH        = 5'h01,
    BSFX_OP_POP         = 5'h02,
    BSFX_OP_IO_SET      = 5'h03,
    BSFX_OP_IO_CLR      = 5'h04,
    BSFX_OP_LOGIC_LEFT  = 5'h05,
    BSFX_OP_LOGIC_RIGHT = 5'h06,
    BSFX_OP_ROT_LEFT    = 5'h07,
    BSFX_OP_ROT_RIGHT   = 5'h08,
    BSFX_OP_SIGNED_RIGHT = 5'h09,
    BSFX_OP_SWAP        = 5'h0a,
    BSFX_OP_FLAG_SET    = 5'h0b,
    BSFX_OP_FLAG_CLR    = 5'h0c,
    BSFX_OP_BIT_TO_FLAG = 5'h0d,
    BSFX_OP_FLAG_TO_BIT = 5'h0e,
    BSFX_OP_SLEEP       = 5'h0f,
    BSFX_OP_WD_RESTART  = 5'h10,
    BSFX_OP_BREAK       = 5'h11
  } bsfx_op_t;
  typedef enum logic [1:0] {
    BSFX_ST_IDLE = 2'b00,
    BSFX_ST_SECOND = 2'b01
  } bsfx_state_t;
endpackage

// ===== rtl/bsfx_shift_alu.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsfx_consts.svh"
module bsfx_shift_alu
  import bsfx_pkg::*;
(
  // Operation and operands.
  input  wire bsfx_op_t   op_in,
  input  wire logic [7:0] data_in,
  input  wire logic       carry_in,
  // Results.
  output logic [7:0]      result_out,
  output logic            carry_out,
  output logic            upd_out
);
  wire logic [7:0] ll_w = {data_in[6:0], 1'b0};
  wire logic [7:0] lr_w = {1'b0, data_in[7:1]};
  wire logic [7:0] rl_w = {data_in[6:0], carry_in};
  wire logic [7:0] rr_w = {carry_in, data_in[7:1]};
  wire logic [7:0] sr_w = {data_in[7], data_in[7:1]};
  wire logic [7:0] sw_w = {data_in[3:0], data_in[7:4]};
  wire logic       left_w = (op_in == BSFX_OP_LOGIC_LEFT) ||
                            (op_in == BSFX_OP_ROT_LEFT);
  assign upd_out = (op_in == BSFX_OP_LOGIC_LEFT) ||
                   (op_in == BSFX_OP_LOGIC_RIGHT) ||
                   (op_in == BSFX_OP_ROT_LEFT) ||
                   (op_in == BSFX_OP_ROT_RIGHT) ||
                   (op_in == BSFX_OP_SIGNED_RIGHT);
  assign carry_out = left_w ? data_in[`BSFX_MSB] : data_in[`BSFX_LSB];
  assign result_out =
    (op_in == BSFX_OP_LOGIC_LEFT)   ? ll_w :
    (op_in == BSFX_OP_LOGIC_RIGHT)  ? lr_w :
    (op_in == BSFX_OP_ROT_LEFT)     ? rl_w :
    (op_in == BSFX_OP_ROT_RIGHT)    ? rr_w :
    (op_in == BSFX_OP_SIGNED_RIGHT) ? sr_w :
    (op_in == BSFX_OP_SWAP)         ? sw_w : data_in;
endmodule
`default_nettype wire

// ===== rtl/bsfx_exec.sv
`timescale 1ns/1ps
`default_nettype none
`include "bsfx_consts.svh"
// Functional notes
// - Push writes the register to the stack in two cycles, flags kept.
// - Pop loads the register from the stack in two cycles, flags kept.
// - Set-I/O-bit sets the chosen I/O bit in two cycles, flags kept.
// - Clear-I/O-bit clears the chosen I/O bit in two cycles, flags kept.
// - Logical shifts fill with zero, one cycle, update Z, C, N, V.
// - Rotate left inserts old carry at bit 0, bit 7 to carry.
// - Rotate right inserts old carry at bit 7, bit 0 to carry.
// - Bit-store copies a register bit into T in one cycle.
// - Bit-load copies T into a register bit, no flag change.
// - Overflow flag set or clear alone in one cycle.
// - Signed-test flag set or clear alone in one cycle.
// - Half-carry flag set or clear alone in one cycle.
// - Sleep issues in one cycle, no flag change.
// - Watchdog restart issues in one cycle, no flag change.
// - Debug break goes to debug support only, no flag change.
module bsfx_exec
  import bsfx_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // Decoded instruction from fetch.
  input  wire logic       issue_in,
  input  wire bsfx_op_t   op_in,
  input  wire logic [4:0] reg_sel_in,
  input  wire logic [2:0] bit_sel_in,
  input  wire logic [5:0] io_addr_in,
  // Register file, stack and I/O read data.
  input  wire logic [7:0] reg_rdata_in,
  input  wire logic [7:0] stack_rdata_in,
  input  wire logic [7:0] io_rdata_in,
  // Status and handshake.
  output logic            busy_out,
  output logic            done_out,
  output logic [7:0]      flag_register_out,
  // Register file write.
  output logic            reg_we_out,
  output logic [4:0]      reg_waddr_out,
  output logic [7:0]      reg_wdata_out,
  // Stack port.
  output logic            stack_push_out,
  output logic            stack_pop_out,
  output logic [7:0]      stack_wdata_out,
  // I/O write port.
  output logic            io_we_out,
  output logic [5:0]      io_addr_out,
  output logic [7:0]      io_wdata_out,
  // Core control pulses.
  output logic            sleep_out,
  output logic            watchdog_restart_out,
  output logic            break_out
);
  // Two-cycle operations latch their operands, so fetch may move on freely.
  bsfx_state_t state_r, state_nxt;
  bsfx_op_t    op_r;
  logic [4:0]  reg_r;
  logic [2:0]  bit_r;
  logic [5:0]  io_r;
  logic [7:0]  flags_r, flags_nxt;
  logic        reg_we_r, reg_we_nxt;
  logic [7:0]  reg_wd_r, reg_wd_nxt;
  logic        push_r, pop_r, io_we_r, done_r;
  logic        sleep_r, wdr_r, brk_r;
  logic [7:0]  io_wd_r;

  wire logic take_w = issue_in && (state_r == BSFX_ST_IDLE);
  wire logic two_w = (op_in == BSFX_OP_PUSH) || (op_in == BSFX_OP_POP) ||
                     (op_in == BSFX_OP_IO_SET) || (op_in == BSFX_OP_IO_CLR);

  function automatic logic [7:0] bsfx_bit_mask(input logic [2:0] b);
    bsfx_bit_mask = 8'h01 << b;
  endfunction

  wire logic [7:0] alu_res_w;
  wire logic       alu_c_w;
  wire logic       alu_upd_w;
  bsfx_shift_alu u_alu (
    .op_in      (op_in),
    .data_in    (reg_rdata_in),
    .carry_in   (flags_r[`BSFX_FLG_C]),
    .result_out (alu_res_w),
    .carry_out  (alu_c_w),
    .upd_out    (alu_upd_w)
  );
  wire logic res_n_w = alu_res_w[`BSFX_MSB];
  wire logic res_v_w = res_n_w ^ alu_c_w;
  wire logic [7:0] mask_w = bsfx_bit_mask(bit_sel_in);
  wire logic [7:0] io_mask_w = bsfx_bit_mask(bit_r);

  always_comb begin
    flags_nxt  = flags_r;
    reg_we_nxt = 1'b0;
    reg_wd_nxt = `BSFX_BYTE_ZERO;
    state_nxt  = state_r;
    case (state_r)
      BSFX_ST_IDLE: begin
        if (take_w) begin
          if (two_w) begin
            state_nxt = BSFX_ST_SECOND;
          end
          if (alu_upd_w) begin
            reg_we_nxt = 1'b1;
            reg_wd_nxt = alu_res_w;
            flags_nxt[`BSFX_FLG_C] = alu_c_w;
            flags_nxt[`BSFX_FLG_Z] = (alu_res_w == `BSFX_BYTE_ZERO);
            flags_nxt[`BSFX_FLG_N] = res_n_w;
            flags_nxt[`BSFX_FLG_V] = res_v_w;
          end else if (op_in == BSFX_OP_SWAP) begin
            reg_we_nxt = 1'b1;
            reg_wd_nxt = alu_res_w;
          end else if (op_in == BSFX_OP_FLAG_SET) begin
            flags_nxt = flags_r | mask_w;
          end else if (op_in == BSFX_OP_FLAG_CLR) begin
            flags_nxt = flags_r & ~mask_w;
          end else if (op_in == BSFX_OP_BIT_TO_FLAG) begin
            flags_nxt[`BSFX_FLG_T] = reg_rdata_in[bit_sel_in];
          end else if (op_in == BSFX_OP_FLAG_TO_BIT) begin
            reg_we_nxt = 1'b1;
            reg_wd_nxt = flags_r[`BSFX_FLG_T] ? (reg_rdata_in | mask_w)
                                              : (reg_rdata_in & ~mask_w);
          end
        end
      end
      BSFX_ST_SECOND: begin
        state_nxt = BSFX_ST_IDLE;
        if (op_r == BSFX_OP_POP) begin
          reg_we_nxt = 1'b1;
          reg_wd_nxt = stack_rdata_in;
        end
      end
      default: state_nxt = BSFX_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r  <= BSFX_ST_IDLE;
      op_r     <= BSFX_OP_NONE;
      reg_r    <= 5'h00;
      bit_r    <= 3'h0;
      io_r     <= 6'h00;
      flags_r  <= `BSFX_FLAGS_RST;
      reg_we_r <= 1'b0;
      reg_wd_r <= `BSFX_BYTE_ZERO;
    end else begin
      state_r  <= state_nxt;
      flags_r  <= flags_nxt;
      reg_we_r <= reg_we_nxt;
      reg_wd_r <= reg_wd_nxt;
      if (take_w) begin
        op_r  <= op_in;
        reg_r <= reg_sel_in;
        bit_r <= bit_sel_in;
        io_r  <= io_addr_in;
      end
    end
  end

  // Side-effect strobes: single pulses plus the I/O write data io_wd_r, registered so outputs are clean.
  wire logic second_w = (state_r == BSFX_ST_SECOND);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      push_r  <= 1'b0;
      pop_r   <= 1'b0;
      io_we_r <= 1'b0;
      io_wd_r <= `BSFX_BYTE_ZERO;
      done_r  <= 1'b0;
      sleep_r <= 1'b0;
      wdr_r   <= 1'b0;
      brk_r   <= 1'b0;
    end else begin
      push_r  <= take_w && (op_in == BSFX_OP_PUSH);
      pop_r   <= take_w && (op_in == BSFX_OP_POP);
      io_we_r <= second_w && ((op_r == BSFX_OP_IO_SET) ||
                              (op_r == BSFX_OP_IO_CLR));
      io_wd_r <= (op_r == BSFX_OP_IO_SET) ? (io_rdata_in | io_mask_w)
                                          : (io_rdata_in & ~io_mask_w);
      done_r  <= (take_w && !two_w) || second_w;
      sleep_r <= take_w && (op_in == BSFX_OP_SLEEP);
      wdr_r   <= take_w && (op_in == BSFX_OP_WD_RESTART);
      brk_r   <= take_w && (op_in == BSFX_OP_BREAK);
    end
  end

  logic [7:0] push_d_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      push_d_r <= `BSFX_BYTE_ZERO;
    end else if (take_w) begin
      push_d_r <= reg_rdata_in;
    end
  end

  assign busy_out             = second_w;
  assign done_out             = done_r;
  assign flag_register_out    = flags_r;
  assign reg_we_out           = reg_we_r;
  assign reg_waddr_out        = reg_r;
  assign reg_wdata_out        = reg_wd_r;
  assign stack_push_out       = push_r;
  assign stack_pop_out        = pop_r;
  assign stack_wdata_out      = push_d_r;
  assign io_we_out            = io_we_r;
  assign io_addr_out          = io_r;
  assign io_wdata_out         = io_wd_r;
  assign sleep_out            = sleep_r;
  assign watchdog_restart_out = wdr_r;
  assign break_out            = brk_r;

  AST_PUSH_KEEPS_FLAGS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_w && op_in == BSFX_OP_PUSH |=> $stable(flags_r) ##1 $stable(flags_r))
    else $error("Push changed flags.");
  AST_POP_WRITES: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_w && op_in == BSFX_OP_POP |=> ##1 reg_we_r)
    else $error("Pop did not write in two cycles.");
  AST_IO_SET: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_w && op_in == BSFX_OP_IO_SET |=> ##1 io_we_r && (io_wd_r & io_mask_w) != 8'h00)
    else $error("I/O bit set failed.");
  AST_IO_CLR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_w && op_in == BSFX_OP_IO_CLR |=> ##1 io_we_r && (io_wd_r & io_mask_w) == 8'h00)
    else $error("I/O bit clear failed.");
  AST_LSL: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_w && op_in == BSFX_OP_LOGIC_LEFT |=> reg_we_r &&
    reg_wd_r == {$past(reg_rdata_in[6:0]), 1'b0} &&
    flags_r[`BSFX_FLG_C] == $past(reg_rdata_in[7]))
    else $error("Logical left wrong.");
  AST_ROL: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_w && op_in == BSFX_OP_ROT_LEFT |=>
    reg_wd_r[0] == $past(flags_r[`BSFX_FLG_C]))
    else $error("Rotate left lost carry.");
  AST_ROR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_w && op_in == BSFX_OP_ROT_RIGHT |=>
    reg_wd_r[7] == $past(flags_r[`BSFX_FLG_C]) &&
    flags_r[`BSFX_FLG_C] == $past(reg_rdata_in[0]))
    else $error("Rotate right wrong.");
  AST_BST: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_w && op_in == BSFX_OP_BIT_TO_FLAG |=>
    flags_r[`BSFX_FLG_T] == $past(reg_rdata_in[bit_sel_in]) && !reg_we_r)
    else $error("Bit store wrong.");
  AST_SLEEP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    take_w && op_in == BSFX_OP_SLEEP |=> sleep_r && $stable(flags_r) ##1 !sleep_r)
    else $error("Sleep pulse wrong.");
endmodule
`default_nettype wire

// ===== testbench/bit_shift_flag_instr_exec_test.sv
`timescale 1ns/1ps
`default_nettype none
module bit_shift_flag_instr_exec_test
  import bsfx_pkg::*;
;
  logic       clk_in = 1'b0;
  logic       rst_n_in, issue_in;
  bsfx_op_t   op_in;
  logic [4:0] reg_sel_in, reg_waddr_out;
  logic [2:0] bit_sel_in;
  logic [5:0] io_addr_in, io_addr_out;
  logic [7:0] reg_rdata_in, stack_rdata_in, io_rdata_in, flag_register_out;
  logic [7:0] reg_wdata_out, stack_wdata_out, io_wdata_out, ef, d, e;
  logic       busy_out, done_out, reg_we_out, stack_push_out, stack_pop_out;
  logic       io_we_out, sleep_out, watchdog_restart_out, break_out;
  logic [8:0] sx;
  logic [31:0] seed = 32'h00015ed8;
  int         miscompares = 0;
  int         n_checks = 0;
  int         cyc = 0;
  bsfx_op_t   o;
  bsfx_op_t   sops [6] = '{BSFX_OP_LOGIC_LEFT, BSFX_OP_LOGIC_RIGHT,
    BSFX_OP_ROT_LEFT, BSFX_OP_ROT_RIGHT, BSFX_OP_SIGNED_RIGHT, BSFX_OP_SWAP};
  bsfx_op_t   tops [4] = '{BSFX_OP_PUSH, BSFX_OP_POP, BSFX_OP_IO_SET,
    BSFX_OP_IO_CLR};
  bsfx_op_t   cops [3] = '{BSFX_OP_SLEEP, BSFX_OP_WD_RESTART, BSFX_OP_BREAK};
  logic [7:0] corner [6] = '{8'h00, 8'h80, 8'h01, 8'hff, 8'h7f, 8'hfe};

  bsfx_exec u_bsfx_exec (.clk_in, .rst_n_in, .issue_in, .op_in, .reg_sel_in,
    .bit_sel_in, .io_addr_in, .reg_rdata_in, .stack_rdata_in, .io_rdata_in,
    .busy_out, .done_out, .flag_register_out, .reg_we_out, .reg_waddr_out,
    .reg_wdata_out, .stack_push_out, .stack_pop_out, .stack_wdata_out,
    .io_we_out, .io_addr_out, .io_wdata_out, .sleep_out,
    .watchdog_restart_out, .break_out);

  always #50 clk_in = ~clk_in;

  // The whole run needs a few hundred cycles, so this only cuts a hang.
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      miscompares++;
      summarize();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Returns the new carry above the shifted byte.
  function automatic logic [8:0] shx(bsfx_op_t p, logic [7:0] v, logic c);
    case (p)
      BSFX_OP_LOGIC_LEFT:   return {v[7], v[6:0], 1'b0};
      BSFX_OP_LOGIC_RIGHT:  return {v[0], 1'b0, v[7:1]};
      BSFX_OP_ROT_LEFT:     return {v[7], v[6:0], c};
      BSFX_OP_ROT_RIGHT:    return {v[0], c, v[7:1]};
      BSFX_OP_SIGNED_RIGHT: return {v[0], v[7], v[7:1]};
      default:              return {c, v[3:0], v[7:4]};
    endcase
  endfunction

  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] x);
    n_checks++;
    if (s !== x) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, x, s);
    end
  endtask

  task automatic summarize();
    if (miscompares == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // A two-cycle op keeps issue high with another op while busy, which the
  // block must ignore; the caller lowers issue one edge later.
  task automatic go(input bsfx_op_t p, input logic [7:0] v,
                    input logic [2:0] b);
    logic [31:0] r;
    logic        two;
    r = rnd();
    two = p inside {BSFX_OP_PUSH, BSFX_OP_POP, BSFX_OP_IO_SET, BSFX_OP_IO_CLR};
    @(posedge clk_in);
    issue_in       <= 1'b1;
    op_in          <= p;
    reg_sel_in     <= r[4:0];
    bit_sel_in     <= b;
    io_addr_in     <= r[10:5];
    reg_rdata_in   <= v;
    stack_rdata_in <= r[18:11];
    io_rdata_in    <= r[26:19];
    @(posedge clk_in);
    if (two)
      op_in <= BSFX_OP_SWAP;
    else
      issue_in <= 1'b0;
    #1;
  endtask

  initial begin
    rst_n_in = 1'b0;
    issue_in = 1'b0;
    op_in = BSFX_OP_NONE;
    reg_sel_in = 5'h00;
    bit_sel_in = 3'h0;
    io_addr_in = 6'h00;
    reg_rdata_in = 8'h00;
    stack_rdata_in = 8'h00;
    io_rdata_in = 8'h00;
    ef = 8'h00;
    repeat (3) @(posedge clk_in);
    chk("flags", flag_register_out, 8'h00);
    chk("busy", busy_out, 8'h00);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      d = rnd();
      o = (i < 8 || d[3]) ? BSFX_OP_FLAG_SET : BSFX_OP_FLAG_CLR;
      go(o, d, (i < 8) ? i[2:0] : d[2:0]);
      ef[bit_sel_in] = (o == BSFX_OP_FLAG_SET);
      chk("flags", flag_register_out, ef);
      chk("done", done_out, 8'h01);
    end
    for (int i = 0; i < 48; i++) begin
      d = (i < 6) ? corner[i] : rnd();
      o = sops[i % 6];
      sx = shx(o, d, ef[0]);
      go(o, d, 3'h0);
      if (o != BSFX_OP_SWAP)
        ef[3:0] = {sx[7] ^ sx[8], sx[7], sx[7:0] == 8'h00, sx[8]};
      chk("wdata", reg_wdata_out, sx[7:0]);
      chk("flags", flag_register_out, ef);
      chk("we", {reg_we_out, reg_waddr_out}, {1'b1, reg_sel_in});
      chk("done", done_out, 8'h01);
    end
    for (int i = 0; i < 16; i++) begin
      d = rnd();
      go(BSFX_OP_BIT_TO_FLAG, d, d[6:4]);
      ef[6] = d[bit_sel_in];
      chk("flags", flag_register_out, ef);
      chk("we", reg_we_out, 8'h00);
      d = rnd();
      go(BSFX_OP_FLAG_TO_BIT, d, d[2:0]);
      e = d;
      e[bit_sel_in] = ef[6];
      chk("wdata", reg_wdata_out, e);
      chk("flags", flag_register_out, ef);
    end
    for (int i = 0; i < 12; i++) begin
      o = tops[i % 4];
      d = rnd();
      go(o, d, d[2:0]);
      chk("busy", busy_out, 8'h01);
      chk("push", stack_push_out, o == BSFX_OP_PUSH);
      chk("pop", stack_pop_out, o == BSFX_OP_POP);
      if (o == BSFX_OP_PUSH) chk("swdata", stack_wdata_out, d);
      @(posedge clk_in);
      issue_in <= 1'b0;
      #1;
      chk("done", done_out, 8'h01);
      chk("rwe", reg_we_out, o == BSFX_OP_POP);
      if (o == BSFX_OP_POP) chk("rdata", reg_wdata_out, stack_rdata_in);
      e = io_rdata_in;
      e[bit_sel_in] = (o == BSFX_OP_IO_SET);
      chk("iowe", io_we_out, o == BSFX_OP_IO_SET || o == BSFX_OP_IO_CLR);
      if (io_we_out === 1'b1) chk("iodata", io_wdata_out, e);
      if (io_we_out === 1'b1) chk("ioaddr", io_addr_out, io_addr_in);
      chk("flags", flag_register_out, ef);
      @(posedge clk_in);
      #1;
      chk("refused", {reg_we_out, done_out}, 8'h00);
    end
    for (int i = 0; i < 3; i++) begin
      go(cops[i], 8'h00, 3'h0);
      chk("sleep", sleep_out, i == 0);
      chk("wdr", watchdog_restart_out, i == 1);
      chk("break", break_out, i == 2);
      chk("flags", flag_register_out, ef);
    end
    summarize();
  end
endmodule
`default_nettype wire
